/* File: src/dbuf_pkg.sv */
// Contract
// - three select lines plus read/write strobes decode eight addresses, reads differ at 0 and 1.
// - writes at address zero fill 15 setup registers via auto-advancing pointer, parking at last.
// - power-on or master reset returns the setup pointer to the first register.
// - a command loads the setup pointer with any index in the bank.
// - low two bits of first setup register pick one of four buffer configurations.
// - linear display addresses up to 16K, comparators keep scanning within programmed limits.
// - independent mode transfers at cursor or pointer address through latch strobes.
// - independent mode touches display memory only during blanking.
// - commands: read/write at pointer, at cursor with optional increment, cursor-to-pointer fill.
// - completion of read, write or fill sets the done flag, read data latched first.
// - command during the active window executes in the next horizontal blanking.
// - command during vertical blanking or display off runs at once, about five char clocks.
// - fill writes one location per two char clocks, only in blanking, until pointer address.
// - immediate commands are accepted at any time regardless of ready state.
// - a ready interrupt can signal completion of a delayed command.
// - acknowledge stays high until bus release has floated the buses, then goes low.
// - transparent mode grants at next blanking; shared mode blanks and grants at once.
// - first handshake line is store strobe in independent mode, request input otherwise.
package dbuf_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [13:0] maddr_type;
  typedef logic [1:0] mode_type;
  typedef logic [2:0] sel_type;

  localparam sel_type SEL_SETUP = 3'h0;
  localparam sel_type SEL_CMD = 3'h1;
  localparam sel_type SEL_SS1_LO = 3'h2;
  localparam sel_type SEL_SS1_HI = 3'h3;
  localparam sel_type SEL_CUR_LO = 3'h4;
  localparam sel_type SEL_CUR_HI = 3'h5;
  localparam sel_type SEL_SS2_LO = 3'h6;
  localparam sel_type SEL_SS2_HI = 3'h7;

  localparam int SETUP_COUNT = 15;
  localparam logic [3:0] SETUP_FIRST = 4'h0;
  localparam logic [3:0] SETUP_LAST = 4'he;
  localparam logic [3:0] IDX_END_LO = 4'h8;
  localparam logic [3:0] IDX_END_HI = 4'h9;
  localparam logic [3:0] IDX_PTR_LO = 4'ha;
  localparam logic [3:0] IDX_PTR_HI = 4'hb;
  localparam logic [3:0] IDX_BEG_LO = 4'hc;
  localparam logic [3:0] IDX_BEG_HI = 4'hd;

  localparam mode_type MODE_INDEP = 2'h0;
  localparam mode_type MODE_TRANSP = 2'h1;
  localparam mode_type MODE_SHARED = 2'h2;
  localparam mode_type MODE_ROWBUF = 2'h3;

  localparam byte_type CMD_MASTER_RESET = 8'h00;
  localparam byte_type CMD_LOAD_PTR = 8'h10;
  localparam byte_type CMD_PTR_MASK = 8'hf0;
  localparam byte_type CMD_DISP_ON = 8'h20;
  localparam byte_type CMD_DISP_OFF = 8'h21;
  localparam byte_type CMD_READY_CLR = 8'h40;
  localparam byte_type CMD_READY_ARM = 8'h41;
  localparam byte_type CMD_RD_PTR = 8'ha4;
  localparam byte_type CMD_WR_PTR = 8'ha2;
  localparam byte_type CMD_RD_CUR = 8'hac;
  localparam byte_type CMD_WR_CUR = 8'haa;
  localparam byte_type CMD_RD_CUR_INC = 8'had;
  localparam byte_type CMD_WR_CUR_INC = 8'hab;
  localparam byte_type CMD_FILL = 8'hbb;

  localparam int ST_DONE = 0;
  localparam int ST_DISP_ON = 1;
  localparam int ST_VBLANK = 2;
  localparam int ST_GRANTED = 3;
  localparam int ST_BUSY = 4;
  localparam int IRQ_READY = 0;

  // durations in character clocks
  localparam logic [2:0] EXEC_TICKS = 3'h5;
  localparam logic [2:0] FILL_TICKS = 3'h2;
  localparam logic [2:0] STROBE_FIRST = 3'h2;
  localparam logic [2:0] STROBE_LAST = 3'h3;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_WAIT = 4'b0010,
    ENG_RUN = 4'b0100,
    ENG_FILL = 4'b1000
  } eng_type;

  typedef enum logic [3:0] {
    GR_IDLE = 4'b0001,
    GR_WAIT = 4'b0010,
    GR_FREE = 4'b0100,
    GR_HOLD = 4'b1000
  } grant_type;

  typedef struct packed {
    logic [2:0] cc_sync;
    logic [2:0] wr_sync;
    logic [1:0] rd_sync;
    logic [1:0] ce_sync;
    logic [1:0] req_sync;
    logic [1:0][2:0] sel_sync;
    logic [1:0][7:0] din_sync;
    sel_type wsel;
    byte_type wdat;
    logic wce;
    logic [14:0][7:0] setup;
    logic [3:0] setup_ptr;
    logic [15:0] ss1;
    logic [15:0] ss2;
    logic [15:0] cursor;
    logic disp_on;
    logic done_flag;
    logic ready_flag;
    logic ready_arm;
    eng_type eng;
    byte_type cmd;
    logic [2:0] tick_cnt;
    maddr_type xfer_addr;
    grant_type grant;
    maddr_type scan_addr;
    logic prev_vblank;
    byte_type dout;
    logic dout_oe_n;
    logic hs1;
    logic hs1_oe_n;
    logic hs2;
    logic hs3;
    maddr_type dadd;
    logic dadd_oe_n;
    logic blank_force;
    logic irq_n;
  } state_type;
endpackage

/* File: src/display_buffer_access_control.sv */
`timescale 1ns/1ps
module display_buffer_access_control (
  input wire logic mclk,
  input wire logic rst,
  input wire dbuf_pkg::sel_type register_select_lines,
  input wire logic chip_enable_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire dbuf_pkg::byte_type data_in,
  output dbuf_pkg::byte_type data_out,
  output logic data_oe_n,
  input wire logic char_clk_n,
  input wire logic hblank,
  input wire logic vblank,
  input wire logic active_window,
  input wire logic handshake_line1_in,
  output logic handshake_line1_out,
  output logic handshake_line1_oe_n,
  output logic handshake_line2,
  output logic handshake_line3,
  output dbuf_pkg::maddr_type display_addr,
  output logic display_addr_oe_n,
  output logic display_blank_force,
  output logic ready_irq_n,
  output dbuf_pkg::mode_type buffer_mode
);
  import dbuf_pkg::*;

  state_type s_r;
  state_type s_nxt;

  function automatic maddr_type join14(input byte_type lo, input byte_type hi);
    join14 = {hi[5:0], lo};
  endfunction

  function automatic logic is_delayed(input byte_type c);
    is_delayed = (c == CMD_RD_PTR) || (c == CMD_WR_PTR) || (c == CMD_RD_CUR) ||
                 (c == CMD_WR_CUR) || (c == CMD_RD_CUR_INC) || (c == CMD_WR_CUR_INC) ||
                 (c == CMD_FILL);
  endfunction

  function automatic logic is_read(input byte_type c);
    is_read = (c == CMD_RD_PTR) || (c == CMD_RD_CUR) || (c == CMD_RD_CUR_INC);
  endfunction

  logic tick;
  logic wr_take;
  logic rd_active;
  logic req_active;
  logic blanking;
  logic strobe_win;
  mode_type mode;
  maddr_type ptr_addr;
  maddr_type end_lim;
  maddr_type beg_lim;

  always_comb begin
    tick = s_r.cc_sync[1] & ~s_r.cc_sync[2];
    wr_take = s_r.wr_sync[1] & ~s_r.wr_sync[2] & s_r.wce;
    rd_active = ~s_r.rd_sync[1] & ~s_r.ce_sync[1];
    req_active = ~s_r.req_sync[1];
    mode = s_r.setup[0][1:0];
    ptr_addr = join14(s_r.setup[IDX_PTR_LO], s_r.setup[IDX_PTR_HI]);
    end_lim = join14(s_r.setup[IDX_END_LO], s_r.setup[IDX_END_HI]);
    beg_lim = join14(s_r.setup[IDX_BEG_LO], s_r.setup[IDX_BEG_HI]);
    // outside the active window, horizontal blanking, vertical blanking or display off qualifies
    blanking = ~s_r.disp_on | vblank | hblank | ~active_window;
    strobe_win = (s_r.tick_cnt >= STROBE_FIRST) && (s_r.tick_cnt <= STROBE_LAST);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.cc_sync = {s_r.cc_sync[1:0], char_clk_n};
    s_nxt.wr_sync = {s_r.wr_sync[1:0], write_n};
    s_nxt.rd_sync = {s_r.rd_sync[0], read_n};
    s_nxt.ce_sync = {s_r.ce_sync[0], chip_enable_n};
    s_nxt.req_sync = {s_r.req_sync[0], handshake_line1_in};
    s_nxt.sel_sync = {s_r.sel_sync[0], register_select_lines};
    s_nxt.din_sync = {s_r.din_sync[0], data_in};
    s_nxt.prev_vblank = vblank;

    // hold address and data while the strobe is low; the write lands on its rising edge
    if (!s_r.wr_sync[1]) begin
      s_nxt.wsel = s_r.sel_sync[1];
      s_nxt.wdat = s_r.din_sync[1];
      s_nxt.wce = ~s_r.ce_sync[1];
    end

    if (wr_take) begin
      case (s_r.wsel)
        SEL_SETUP: begin
          s_nxt.setup[s_r.setup_ptr] = s_r.wdat;
          if (s_r.setup_ptr != SETUP_LAST) begin
            s_nxt.setup_ptr = 4'(s_r.setup_ptr + 4'h1);
          end
        end
        SEL_CMD: begin
          // immediate commands never look at the engine or ready state
          if (s_r.wdat == CMD_MASTER_RESET) begin
            s_nxt.setup_ptr = SETUP_FIRST;
            s_nxt.disp_on = 1'b0;
            s_nxt.eng = ENG_IDLE;
            s_nxt.grant = GR_IDLE;
            s_nxt.done_flag = 1'b1;
            s_nxt.ready_flag = 1'b0;
            s_nxt.ready_arm = 1'b0;
          end else if ((s_r.wdat & CMD_PTR_MASK) == CMD_LOAD_PTR) begin
            s_nxt.setup_ptr = (s_r.wdat[3:0] > SETUP_LAST) ? SETUP_LAST : s_r.wdat[3:0];
          end else if (s_r.wdat == CMD_DISP_ON) begin
            s_nxt.disp_on = 1'b1;
          end else if (s_r.wdat == CMD_DISP_OFF) begin
            s_nxt.disp_on = 1'b0;
          end else if (s_r.wdat == CMD_READY_CLR || s_r.wdat == CMD_READY_ARM) begin
            s_nxt.ready_flag = 1'b0;
            s_nxt.ready_arm = s_r.wdat[0];
          end else if (is_delayed(s_r.wdat) && s_r.eng == ENG_IDLE &&
                       mode == MODE_INDEP) begin
            s_nxt.cmd = s_r.wdat;
            s_nxt.done_flag = 1'b0;
            s_nxt.eng = ENG_WAIT;
            s_nxt.xfer_addr = (s_r.wdat == CMD_RD_PTR || s_r.wdat == CMD_WR_PTR) ?
                              ptr_addr : s_r.cursor[13:0];
          end
        end
        SEL_SS1_LO: s_nxt.ss1[7:0] = s_r.wdat;
        SEL_SS1_HI: s_nxt.ss1[15:8] = s_r.wdat;
        SEL_CUR_LO: s_nxt.cursor[7:0] = s_r.wdat;
        SEL_CUR_HI: s_nxt.cursor[15:8] = s_r.wdat;
        SEL_SS2_LO: s_nxt.ss2[7:0] = s_r.wdat;
        SEL_SS2_HI: s_nxt.ss2[15:8] = s_r.wdat;
        default: s_nxt.wce = 1'b0;
      endcase
    end

    // transfer engine, stepped by the character clock
    case (s_r.eng)
      ENG_IDLE: s_nxt.tick_cnt = 3'h0;
      ENG_WAIT: begin
        if (tick && blanking) begin
          s_nxt.eng = (s_r.cmd == CMD_FILL) ? ENG_FILL : ENG_RUN;
          s_nxt.tick_cnt = 3'h0;
        end
      end
      ENG_RUN: begin
        if (tick) begin
          s_nxt.tick_cnt = 3'(s_r.tick_cnt + 3'h1);
          if (s_r.tick_cnt == 3'(EXEC_TICKS - 3'h1)) begin
            s_nxt.eng = ENG_IDLE;
            s_nxt.done_flag = 1'b1;
            s_nxt.ready_flag = 1'b1;
            if (s_r.cmd == CMD_RD_CUR_INC || s_r.cmd == CMD_WR_CUR_INC) begin
              s_nxt.cursor = {s_r.cursor[15:14], 14'(s_r.cursor[13:0] + 14'h1)};
            end
          end
        end
      end
      ENG_FILL: begin
        // a fill stalls across active video and resumes at the next blanking
        if (tick && blanking) begin
          if (s_r.tick_cnt == 3'(FILL_TICKS - 3'h1)) begin
            s_nxt.tick_cnt = 3'h0;
            if (s_r.xfer_addr == ptr_addr) begin
              s_nxt.eng = ENG_IDLE;
              s_nxt.done_flag = 1'b1;
              s_nxt.ready_flag = 1'b1;
            end else begin
              s_nxt.xfer_addr = 14'(s_r.xfer_addr + 14'h1);
            end
          end else begin
            s_nxt.tick_cnt = 3'(s_r.tick_cnt + 3'h1);
          end
        end
      end
      default: s_nxt.eng = ENG_IDLE;
    endcase

    // host buffer grant for transparent and shared modes
    if ((mode != MODE_TRANSP && mode != MODE_SHARED) || !req_active) begin
      s_nxt.grant = GR_IDLE;
    end else begin
      case (s_r.grant)
        GR_IDLE: s_nxt.grant = GR_WAIT;
        GR_WAIT: begin
          if (tick && (mode == MODE_SHARED || blanking)) begin
            s_nxt.grant = GR_FREE;
          end
        end
        GR_FREE: begin
          if (tick) begin
            s_nxt.grant = GR_HOLD;
          end
        end
        GR_HOLD: s_nxt.grant = GR_HOLD;
        default: s_nxt.grant = GR_IDLE;
      endcase
    end

    // display scan address with wraparound between programmed limits
    if (vblank && !s_r.prev_vblank) begin
      s_nxt.scan_addr = s_r.ss1[13:0];
    end else if (tick && s_r.disp_on && !hblank && !vblank) begin
      s_nxt.scan_addr = (s_r.scan_addr == end_lim) ? beg_lim :
                        14'(s_r.scan_addr + 14'h1);
    end

    // read port
    s_nxt.dout_oe_n = ~rd_active;
    case (s_r.sel_sync[1])
      SEL_SETUP: s_nxt.dout = {7'h00, s_r.ready_flag};
      SEL_CMD: s_nxt.dout = {3'h0, s_r.eng != ENG_IDLE, s_r.grant == GR_HOLD,
                             vblank, s_r.disp_on, s_r.done_flag};
      SEL_SS1_LO: s_nxt.dout = s_r.ss1[7:0];
      SEL_SS1_HI: s_nxt.dout = s_r.ss1[15:8];
      SEL_CUR_LO: s_nxt.dout = s_r.cursor[7:0];
      SEL_CUR_HI: s_nxt.dout = s_r.cursor[15:8];
      SEL_SS2_LO: s_nxt.dout = s_r.ss2[7:0];
      SEL_SS2_HI: s_nxt.dout = s_r.ss2[15:8];
      default: s_nxt.dout = 8'h00;
    endcase

    // handshake outputs, all inactive high unless a phase calls for them
    s_nxt.hs1 = 1'b1;
    s_nxt.hs1_oe_n = (mode != MODE_INDEP);
    s_nxt.hs2 = 1'b1;
    s_nxt.hs3 = 1'b1;
    s_nxt.dadd = s_r.scan_addr;
    s_nxt.dadd_oe_n = 1'b0;
    s_nxt.blank_force = 1'b0;
    if (mode == MODE_INDEP) begin
      if (s_r.eng == ENG_RUN) begin
        s_nxt.dadd = s_r.xfer_addr;
        s_nxt.hs3 = ~(s_r.tick_cnt != 3'h0);
        if (strobe_win) begin
          s_nxt.hs2 = ~is_read(s_r.cmd);
          s_nxt.hs1 = is_read(s_r.cmd);
        end
      end else if (s_r.eng == ENG_FILL && blanking) begin
        s_nxt.dadd = s_r.xfer_addr;
        s_nxt.hs3 = 1'b0;
        s_nxt.hs1 = (s_r.tick_cnt == 3'h0);
      end
    end else if (mode == MODE_TRANSP || mode == MODE_SHARED) begin
      s_nxt.blank_force = (mode == MODE_SHARED) && (s_r.grant != GR_IDLE);
      if (s_r.grant == GR_FREE || s_r.grant == GR_HOLD) begin
        s_nxt.hs2 = 1'b0;
        s_nxt.dadd_oe_n = 1'b1;
      end
      s_nxt.hs3 = (s_r.grant != GR_HOLD);
    end
    s_nxt.irq_n = ~(s_r.ready_flag & s_r.ready_arm);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.cc_sync <= 3'h7;
      s_r.wr_sync <= 3'h7;
      s_r.rd_sync <= 2'h3;
      s_r.ce_sync <= 2'h3;
      s_r.req_sync <= 2'h3;
      s_r.setup_ptr <= SETUP_FIRST;
      s_r.done_flag <= 1'b1;
      s_r.eng <= ENG_IDLE;
      s_r.grant <= GR_IDLE;
      s_r.dout_oe_n <= 1'b1;
      s_r.hs1 <= 1'b1;
      s_r.hs2 <= 1'b1;
      s_r.hs3 <= 1'b1;
      s_r.irq_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_out = s_r.dout;
  assign data_oe_n = s_r.dout_oe_n;
  assign handshake_line1_out = s_r.hs1;
  assign handshake_line1_oe_n = s_r.hs1_oe_n;
  assign handshake_line2 = s_r.hs2;
  assign handshake_line3 = s_r.hs3;
  assign display_addr = s_r.dadd;
  assign display_addr_oe_n = s_r.dadd_oe_n;
  assign display_blank_force = s_r.blank_force;
  assign ready_irq_n = s_r.irq_n;
  assign buffer_mode = s_r.setup[0][1:0];
endmodule

/* File: verif/dbuf_checker_sva.sv */
`timescale 1ns/1ps
module dbuf_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_enable_n,
  input wire logic read_n,
  input wire logic data_oe_n,
  input wire logic handshake_line1_in,
  input wire logic handshake_line1_out,
  input wire logic handshake_line1_oe_n,
  input wire logic handshake_line2,
  input wire logic handshake_line3,
  input wire logic display_addr_oe_n,
  input wire dbuf_pkg::mode_type buffer_mode
);
  import dbuf_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_host_mode;
    buffer_mode == MODE_TRANSP || buffer_mode == MODE_SHARED;
  endsequence
  sequence s_released;
    !handshake_line2 && display_addr_oe_n;
  endsequence

  chk_line1_drive: assert property (
    (buffer_mode == MODE_INDEP)[*2] |-> !handshake_line1_oe_n)
    else $error("line 1 floated in independent mode");
  chk_store_select: assert property (
    buffer_mode == MODE_INDEP && !handshake_line1_out |-> !handshake_line3)
    else $error("store strobe without buffer select");
  chk_strobe_excl: assert property (
    buffer_mode == MODE_INDEP |-> handshake_line1_out || handshake_line2)
    else $error("store and load strobes both low");
  chk_ack_release: assert property (
    s_host_mode ##0 !handshake_line3 |-> s_released)
    else $error("acknowledge low while buses still driven");
  chk_ack_order: assert property (
    s_host_mode ##0 $fell(handshake_line3) |-> $past(handshake_line2) == 1'b0)
    else $error("acknowledge fell before bus release");
  chk_req_drop: assert property (
    (buffer_mode != MODE_INDEP && handshake_line1_in)[*5] |-> handshake_line3)
    else $error("acknowledge low without request");
  chk_shared_grant: assert property (
    buffer_mode == MODE_SHARED && $fell(handshake_line1_in) |-> ##[1:40] !handshake_line3)
    else $error("shared grant too late");
  chk_read_drive: assert property (
    (!read_n && !chip_enable_n)[*4] |-> !data_oe_n)
    else $error("read data not driven");
endmodule

bind display_buffer_access_control dbuf_checker i_chk (
  .mclk(mclk), .rst(rst), .chip_enable_n(chip_enable_n), .read_n(read_n),
  .data_oe_n(data_oe_n), .handshake_line1_in(handshake_line1_in),
  .handshake_line1_out(handshake_line1_out), .handshake_line1_oe_n(handshake_line1_oe_n),
  .handshake_line2(handshake_line2), .handshake_line3(handshake_line3),
  .display_addr_oe_n(display_addr_oe_n), .buffer_mode(buffer_mode)
);

/* File: verif/dbuf_mem_model.sv */
`timescale 1ns/1ps
module dbuf_mem_model (
  input wire logic mclk,
  input wire logic store_n,
  input wire logic indep_n,
  input wire logic load_n,
  input wire logic select_n,
  input wire dbuf_pkg::maddr_type addr,
  input wire logic host_wr,
  input wire dbuf_pkg::byte_type host_data
);
  import dbuf_pkg::*;
  byte_type mem [0:16383];
  byte_type latch = 8'h00;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // strobes only count while the controller owns line 1
  always @(posedge mclk) begin
    if (host_wr) begin
      latch <= host_data;
    end else if (!indep_n && !select_n && !load_n) begin
      latch <= mem[addr];
    end
    if (!indep_n && !select_n && !store_n) begin
      mem[addr] <= latch;
    end
  end
endmodule

/* File: verif/tb_display_buffer_access_control.sv */
`timescale 1ns/1ps
module tb_display_buffer_access_control;
  import dbuf_pkg::*;
  localparam maddr_type PTR = 14'h0123;
  logic mclk, rst, ce_n, rd_n, wr_n, cclk_n, hblank, vblank, awin, req_n, lwr;
  logic oe_n, h1o, h1oe, h2, h3, aoe, bf, irq_n;
  logic [1:0] cc = 2'h0;
  sel_type sel;
  byte_type din, dout, lval, rv, rh;
  maddr_type da, ea, cur;
  mode_type mode;
  byte_type cmds [6] = '{CMD_WR_PTR, CMD_WR_CUR_INC, CMD_WR_CUR, CMD_RD_PTR,
    CMD_RD_CUR_INC, CMD_RD_CUR};
  int n_mismatch = 0;
  int tests_run = 0;
  // shared pin: controller strobe in independent mode, host request otherwise
  wire line1 = !h1oe ? h1o : req_n;

  display_buffer_access_control i_dut (
    .mclk(mclk), .rst(rst), .register_select_lines(sel), .chip_enable_n(ce_n),
    .read_n(rd_n), .write_n(wr_n), .data_in(din), .data_out(dout), .data_oe_n(oe_n),
    .char_clk_n(cclk_n), .hblank(hblank), .vblank(vblank), .active_window(awin),
    .handshake_line1_in(line1), .handshake_line1_out(h1o), .handshake_line1_oe_n(h1oe),
    .handshake_line2(h2), .handshake_line3(h3), .display_addr(da),
    .display_addr_oe_n(aoe), .display_blank_force(bf), .ready_irq_n(irq_n),
    .buffer_mode(mode)
  );
  dbuf_mem_model i_mem (
    .mclk(mclk), .store_n(h1o), .indep_n(h1oe), .load_n(h2), .select_n(h3),
    .addr(da), .host_wr(lwr), .host_data(lval)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input sel_type a, input byte_type d);
    sel <= a;
    din <= d;
    ce_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (4) @(posedge mclk);
    wr_n <= 1'b1;
    ce_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask

  task automatic rreg(input sel_type a, output byte_type d);
    sel <= a;
    ce_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    d = dout;
    chk(oe_n, 1'b0);
    @(posedge mclk);
    rd_n <= 1'b1;
    ce_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  task automatic setreg(input logic [3:0] idx, input byte_type v);
    wreg(SEL_CMD, CMD_LOAD_PTR | {4'h0, idx});
    wreg(SEL_SETUP, v);
  endtask

  task automatic lat(input byte_type v);
    lval <= v;
    lwr <= 1'b1;
    @(posedge mclk);
    lwr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wdone(input int lim);
    for (int i = 0; i < lim; i++) begin
      rreg(SEL_CMD, rv);
      if (rv[ST_DONE] === 1'b1) return;
    end
    chk(rv[ST_DONE], 1'b1);
  endtask

  task automatic wack();
    for (int i = 0; i < 40 && h3 !== 1'b0; i++) @(negedge mclk);
    chk({h3, h2, aoe}, 3'b001);
    @(posedge mclk);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // character clock at a quarter of the system clock
  always @(posedge mclk) begin
    cc <= cc + 2'h1;
    cclk_n <= cc[1];
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    {ce_n, rd_n, wr_n, cclk_n, req_n, vblank} = 6'h3f;
    {hblank, awin, lwr} = 3'h0;
    sel = SEL_SETUP;
    din = 8'h00;
    lval = 8'h00;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({h1o, h2, h3, irq_n, oe_n, h1oe, mode}, 8'hf8);
    chk({aoe, da}, 16'h0000);
    rreg(SEL_CMD, rv);
    chk(rv[4:0], 5'h05);
    for (int a = 2; a < 8; a++) wreg(sel_type'(a), 8'h30 + 8'(a));
    for (int a = 2; a < 8; a++) begin
      rreg(sel_type'(a), rv);
      chk(rv, 8'h30 + 8'(a));
    end
    wreg(SEL_CMD, CMD_MASTER_RESET);
    wreg(SEL_SETUP, {6'h0, MODE_SHARED});
    chk(mode, MODE_SHARED);
    wreg(SEL_SETUP, 8'h03);
    chk(mode, MODE_SHARED);
    for (int m = 0; m < 4; m++) begin
      setreg(4'h0, 8'(m));
      chk({h1oe, mode}, {m != 0, 2'(m)});
    end
    wreg(SEL_CMD, CMD_MASTER_RESET);
    for (int i = 0; i < 17; i++) wreg(SEL_SETUP, i == 10 ? PTR[7:0] :
      i == 11 ? {2'h0, PTR[13:8]} : i > 14 ? 8'h03 : 8'h00);
    chk(mode, MODE_INDEP);
    wreg(SEL_CUR_LO, 8'h00);
    wreg(SEL_CUR_HI, 8'h02);
    cur = 14'h0200;
    foreach (cmds[i]) begin
      ea = cmds[i][3] ? cur : PTR;
      lat(cmds[i][2] ? 8'hee : 8'h50 + 8'(i));
      if (cmds[i][2]) i_mem.mem[ea] = 8'h50 + 8'(i);
      wreg(SEL_CMD, cmds[i]);
      wdone(4);
      chk(cmds[i][2] ? i_mem.latch : i_mem.mem[ea], 8'h50 + 8'(i));
      cur = cur + 14'(cmds[i][0]);
      rreg(SEL_CUR_LO, rv);
      rreg(SEL_CUR_HI, rh);
      chk({rh[5:0], rv}, cur);
    end
    wreg(SEL_CMD, CMD_DISP_ON);
    vblank <= 1'b0;
    awin <= 1'b1;
    lat(8'h77);
    wreg(SEL_CMD, CMD_WR_PTR);
    wreg(SEL_CMD, CMD_READY_ARM);
    repeat (40) @(posedge mclk);
    rreg(SEL_CMD, rv);
    chk({rv[ST_DONE], irq_n, i_mem.mem[PTR]}, {2'b01, 8'h53});
    hblank <= 1'b1;
    wdone(4);
    chk({irq_n, i_mem.mem[PTR]}, {1'b0, 8'h77});
    rreg(SEL_SETUP, rv);
    chk(rv, 8'h01);
    wreg(SEL_CMD, CMD_READY_CLR);
    rreg(SEL_SETUP, rv);
    chk({irq_n, rv}, 9'h100);
    hblank <= 1'b0;
    vblank <= 1'b1;
    lat(8'hcc);
    wreg(SEL_CUR_LO, 8'h00);
    wreg(SEL_CUR_HI, 8'h03);
    setreg(IDX_PTR_LO, 8'h03);
    setreg(IDX_PTR_HI, 8'h03);
    wreg(SEL_CMD, CMD_FILL);
    repeat (8) @(posedge mclk);
    chk(i_mem.mem[14'h303], 8'h00);
    wdone(8);
    for (int a = 14'h2ff; a < 14'h305; a++) begin
      chk(i_mem.mem[a], (a > 14'h2ff && a < 14'h304) ? 8'hcc : 8'h00);
    end
    setreg(4'h0, {6'h0, MODE_SHARED});
    req_n <= 1'b0;
    wack();
    chk(bf, 1'b1);
    req_n <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({h3, bf}, 2'b10);
    setreg(4'h0, {6'h0, MODE_TRANSP});
    vblank <= 1'b0;
    req_n <= 1'b0;
    repeat (40) @(posedge mclk);
    chk(h3, 1'b1);
    hblank <= 1'b1;
    wack();
    req_n <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(h3, 1'b1);
    end_of_test();
  end
endmodule
